/* File: design/fault_history_buffer.sv */
/*
  Fault history block: comparator deglitch, channel latch-off and two
  sample histories behind a byte register port fed by the serial engine.
  Assumes the serial engine gives one-cycle byte strobes with an address.
*/
module fault_history_buffer
  import history_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_rd,
  output logic [7:0]               reg_rdata,
  input  wire logic                adc_valid,
  output logic                     adc_ready,
  input  wire logic                adc_is_current,
  input  wire logic [SAMPLE_W-1:0] adc_data,
  input  wire logic                cmp_sample,
  input  wire logic [NUM_CMP-1:0]  cmp_exceed,
  output logic [NUM_CMP-1:0]       cmp_act,
  input  wire logic                protection_mode_input,
  input  wire logic                overcurrent_trip,
  input  wire logic                on_input,
  input  wire logic                soft_enable_a,
  input  wire logic                soft_enable_b,
  output logic                     channel_on
);
  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [3:0] run_q, run_d, res_q, res_d;
  logic [5:0] dly_q, dly_d;
  logic       dgl_i_q, dgl_i_d;
  logic [1:0] undervolt_deglitch_q, undervolt_deglitch_d, overvolt_deglitch_q, overvolt_deglitch_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] vbyte, ibyte;
  logic [1:0] port_rd;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction : hit

  assign port_rd[0] = reg_rd && hit(reg_addr, ADDR_VPORT);
  assign port_rd[1] = reg_rd && hit(reg_addr, ADDR_IPORT);
  assign reg_rdata  = rdata_q;

  // Writes land on the control fields; reads latch the addressed byte.
  always_comb
  begin
    run_d    = run_q;
    res_d    = res_q;
    dly_d    = dly_q;
    dgl_i_d  = dgl_i_q;
    undervolt_deglitch_d = undervolt_deglitch_q;
    overvolt_deglitch_d = overvolt_deglitch_q;
    rdata_d  = rdata_q;
    if (reg_wr)
    begin
      if (hit(reg_addr, ADDR_RUN))
        run_d = reg_wdata[3:0];
      if (hit(reg_addr, ADDR_RES))
        res_d = reg_wdata[3:0];
      if (hit(reg_addr, ADDR_DLY))
        dly_d = reg_wdata[5:0];
      if (hit(reg_addr, ADDR_DGL_I))
        dgl_i_d = reg_wdata[DGL_WARN];
      if (hit(reg_addr, ADDR_UNDERVOLT_DEGLITCH))
        undervolt_deglitch_d = reg_wdata[1:0];
      if (hit(reg_addr, ADDR_OVERVOLT_DEGLITCH))
        overvolt_deglitch_d = reg_wdata[1:0];
    end
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_RUN:    rdata_d = {4'h0, run_q};
        ADDR_RES:    rdata_d = {4'h0, res_q};
        ADDR_DLY:    rdata_d = {2'h0, dly_q};
        ADDR_DGL_I:  rdata_d = {7'h00, dgl_i_q};
        ADDR_UNDERVOLT_DEGLITCH: rdata_d = {6'h00, undervolt_deglitch_q};
        ADDR_OVERVOLT_DEGLITCH: rdata_d = {6'h00, overvolt_deglitch_q};
        ADDR_VPORT:  rdata_d = vbyte;
        ADDR_IPORT:  rdata_d = ibyte;
        default:     rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      run_q    <= RUN_RST;
      res_q    <= RES_RST;
      dly_q    <= DLY_RST;
      dgl_i_q  <= 1'b0;
      undervolt_deglitch_q <= DGL_RST;
      overvolt_deglitch_q <= DGL_RST;
      rdata_q  <= 8'h00;
    end
    else
    begin
      run_q    <= run_d;
      res_q    <= res_d;
      dly_q    <= dly_d;
      dgl_i_q  <= dgl_i_d;
      undervolt_deglitch_q <= undervolt_deglitch_d;
      overvolt_deglitch_q <= overvolt_deglitch_d;
      rdata_q  <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Comparator deglitch and channel latch-off
  // ---------------------------------------------------------------
  logic [NUM_CMP-1:0] dgl_en, prev_q, prev_d, act_q, act_d;
  chan_state_t        st_q, st_d;
  logic               en_all, trip;

  assign dgl_en  = {overvolt_deglitch_q[DGL_CRIT], overvolt_deglitch_q[DGL_WARN],
                    undervolt_deglitch_q[DGL_CRIT], undervolt_deglitch_q[DGL_WARN], dgl_i_q};
  assign cmp_act = act_q;
  assign en_all  = on_input && soft_enable_a && soft_enable_b;
  // Critical voltage compares shut the channel only in protective mode.
  assign trip    = overcurrent_trip || (protection_mode_input
                   && (act_q[CMP_UV_C] || act_q[CMP_OV_C]));
  assign channel_on = (st_q == CH_ON);

  // One compare acts alone unless deglitch asks for a second in a row.
  always_comb
  begin
    prev_d = prev_q;
    act_d  = '0;
    if (cmp_sample)
    begin
      act_d  = cmp_exceed & (prev_q | ~dgl_en);
      prev_d = cmp_exceed;
    end
    st_d = st_q;
    case (st_q)
      CH_OFF:     st_d = en_all ? CH_ON : CH_OFF;
      CH_ON:      st_d = !en_all ? CH_OFF : (trip ? CH_LATCHED : CH_ON);
      CH_LATCHED: st_d = en_all ? CH_LATCHED : CH_OFF;
      default:    st_d = CH_OFF;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      prev_q <= '0;
      act_q  <= '0;
      st_q   <= CH_OFF;
    end
    else
    begin
      prev_q <= prev_d;
      act_q  <= act_d;
      st_q   <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Sample path and the two histories
  // ---------------------------------------------------------------
  logic [SAMPLE_W:0] buf_out;
  logic              buf_valid, buf_ready;
  logic [1:0]        frz_q, frz_d, stop_q, stop_d, take, rec;
  logic [5:0]        post_q [2];
  logic [5:0]        post_d [2];
  logic [7:0]        hist_byte [2];

  // A port read stalls the drain; the buffer absorbs ADC words meanwhile.
  assign buf_ready = !(|port_rd);
  // Each ring answers on its own lane; the read mux above picks by address.
  assign vbyte     = hist_byte[0];
  assign ibyte     = hist_byte[1];

  pair_buffer #(.W(SAMPLE_W + 1)) u_buf (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (adc_valid),
    .in_ready  (adc_ready),
    .in_data   ({adc_is_current, adc_data}),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_out)
  );

  for (genvar h = 0; h < 2; h++)
  begin : g_hist
    localparam int RB = (h == 0) ? BIT_V : BIT_I;
    assign take[h] = buf_valid && buf_ready && (buf_out[SAMPLE_W] == 1'(h));
    // Recording needs run set, no freeze, no stop and the enables on.
    assign rec[h]  = take[h] && run_q[RB] && !frz_q[h] && !stop_q[h]
                     && en_all && (post_q[h] < dly_q || st_q != CH_LATCHED);

    always_comb
    begin
      frz_d[h]  = frz_q[h];
      stop_d[h] = stop_q[h];
      post_d[h] = post_q[h];
      // A run-control write releases the freeze; the base read sets it.
      if (reg_wr && hit(reg_addr, ADDR_RUN))
        frz_d[h] = 1'b0;
      if (port_rd[h])
        frz_d[h] = 1'b1;
      if (st_q != CH_LATCHED)
      begin
        stop_d[h] = 1'b0;
        post_d[h] = 6'h00;
      end
      else if (take[h] && !stop_q[h])
      begin
        if (post_q[h] >= dly_q)
          stop_d[h] = 1'b1;
        else
          post_d[h] = post_q[h] + 6'h01;
      end
    end

    always_ff @(posedge clock)
    begin
      if (rst)
      begin
        frz_q[h]  <= 1'b0;
        stop_q[h] <= 1'b0;
        post_q[h] <= 6'h00;
      end
      else
      begin
        frz_q[h]  <= frz_d[h];
        stop_q[h] <= stop_d[h];
        post_q[h] <= post_d[h];
      end
    end

    history_ring u_ring (
      .clock     (clock),
      .rst       (rst),
      .wr_valid  (rec[h]),
      .wr_data   (buf_out[SAMPLE_W-1:0]),
      .rd_take   (port_rd[h]),
      .rd_hibyte (res_q[RB]),
      .rd_rewind (reg_wr && hit(reg_addr, ADDR_RUN)),
      .rd_byte   (hist_byte[h])
    );
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_dgl_two_hits: assert property (@(posedge clock) disable iff (rst)
    cmp_sample && dgl_en[CMP_UV_W] && !prev_q[CMP_UV_W] |=> !act_q[CMP_UV_W])
    else $error("deglitched compare acted on a single hit");
  a_dgl_off_single: assert property (@(posedge clock) disable iff (rst)
    cmp_sample && !dgl_en[CMP_OI] && cmp_exceed[CMP_OI] |=> act_q[CMP_OI])
    else $error("plain compare did not act");
  a_dgl_reset_zero: assert property (@(posedge clock)
    rst |=> (dgl_en == '0))
    else $error("deglitch enables not cleared by reset");
  a_run_reset: assert property (@(posedge clock)
    rst |=> run_q[BIT_V] && run_q[BIT_I] && dly_q == 6'd25)
    else $error("run bits or stop delay wrong after reset");
  a_freeze_read: assert property (@(posedge clock) disable iff (rst)
    port_rd[0] |=> frz_q[0] && !rec[0])
    else $error("voltage history kept recording after base read");
  a_off_stops: assert property (@(posedge clock) disable iff (rst)
    !en_all |-> rec == 2'b00)
    else $error("recording while channel switched off");
  a_latch_hold: assert property (@(posedge clock) disable iff (rst)
    st_q == CH_LATCHED && en_all |=> st_q == CH_LATCHED)
    else $error("latched channel restarted without toggle");
  a_trip_latch: assert property (@(posedge clock) disable iff (rst)
    st_q == CH_ON && en_all && trip |=> !channel_on ##1 !channel_on)
    else $error("trip did not latch the channel off");
  a_stop_delay: assert property (@(posedge clock) disable iff (rst)
    $rose(stop_q[0]) |-> post_q[0] >= $past(dly_q))
    else $error("voltage history stopped before its delay");
  a_lsb_byte: assert property (@(posedge clock) disable iff (rst)
    port_rd[0] && !res_q[BIT_V] && g_hist[0].u_ring.phase_q |=> reg_rdata[7:2] == 6'h00)
    else $error("second byte of a sample carries more than two bits");
endmodule : fault_history_buffer

/* File: design/history_pkg.sv */
/*
  Shared constants for the fault history block: register offsets, field
  positions, reset values, sizes and the channel state type.
  Assumes nothing of its surroundings.
*/
package history_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_RUN    = 8'h19;
  localparam logic [7:0] ADDR_DGL_I  = 8'h3c;
  localparam logic [7:0] ADDR_UNDERVOLT_DEGLITCH = 8'h3d;
  localparam logic [7:0] ADDR_OVERVOLT_DEGLITCH = 8'h3e;
  localparam logic [7:0] ADDR_RES    = 8'h3f;
  localparam logic [7:0] ADDR_DLY    = 8'h40;
  localparam logic [7:0] ADDR_VPORT  = 8'h46;
  localparam logic [7:0] ADDR_IPORT  = 8'h47;
  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [3:0] RUN_RST  = 4'hf;
  localparam logic [3:0] RES_RST  = 4'hf;
  localparam logic [5:0] DLY_RST  = 6'h19;
  localparam logic [1:0] DGL_RST  = 2'h0;
  localparam int         BIT_V    = 0;
  localparam int         BIT_I    = 2;
  localparam int         DGL_WARN = 0;
  localparam int         DGL_CRIT = 1;
  // Comparator order on the raw compare and action vectors.
  localparam int CMP_OI   = 0;
  localparam int CMP_UV_W = 1;
  localparam int CMP_UV_C = 2;
  localparam int CMP_OV_W = 3;
  localparam int CMP_OV_C = 4;
  localparam int NUM_CMP  = 5;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int HIST_DEPTH = 50;
  localparam int SAMPLE_W   = 10;
  // Gray order along off, on, latched.
  typedef enum logic [1:0] {
    CH_OFF     = 2'b00,
    CH_ON      = 2'b01,
    CH_LATCHED = 2'b11
  } chan_state_t;
endpackage : history_pkg

/* File: design/history_ring.sv */
/*
  One circular sample history with byte-wise read-out, oldest first.
  Assumes the caller never writes and reads it in the same cycle.
*/
module history_ring
  import history_pkg::*;
#(
  parameter int DEPTH = HIST_DEPTH,
  parameter int W     = SAMPLE_W
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         wr_valid,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         rd_take,
  input  wire logic         rd_hibyte,
  input  wire logic         rd_rewind,
  output logic [7:0]        rd_byte
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [W-1:0]  mem_d [DEPTH];
  logic [PW-1:0] wptr_q, wptr_d, ridx_q, ridx_d, oldest, pos;
  logic [PW:0]   sum;
  logic          full_q, full_d, phase_q, phase_d;
  logic [W-1:0]  sample;

  // Oldest entry is the write pointer once the ring has wrapped.
  assign oldest  = full_q ? wptr_q : '0;
  assign sum     = {1'b0, oldest} + {1'b0, ridx_q};
  assign pos     = (sum > {1'b0, LAST}) ? PW'(sum - DEPTH) : sum[PW-1:0];
  assign sample  = mem_q[pos];
  // High byte first, then the two low bits in the low lanes.
  assign rd_byte = (rd_hibyte || !phase_q) ? sample[W-1:W-8]
                                           : {6'h00, sample[1:0]};

  // New samples overwrite the oldest; each read advances by byte.
  always_comb
  begin
    mem_d   = mem_q;
    wptr_d  = wptr_q;
    full_d  = full_q;
    ridx_d  = ridx_q;
    phase_d = phase_q;
    if (wr_valid)
    begin
      mem_d[wptr_q] = wr_data;
      wptr_d = (wptr_q == LAST) ? '0 : wptr_q + 1'b1;
      full_d = full_q || (wptr_q == LAST);
    end
    if (wr_valid || rd_rewind)
    begin
      ridx_d  = '0;
      phase_d = 1'b0;
    end
    else if (rd_take)
    begin
      if (rd_hibyte || phase_q)
      begin
        ridx_d  = (ridx_q == LAST) ? '0 : ridx_q + 1'b1;
        phase_d = 1'b0;
      end
      else
        phase_d = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wptr_q  <= '0;
      full_q  <= 1'b0;
      ridx_q  <= '0;
      phase_q <= 1'b0;
    end
    else
    begin
      wptr_q  <= wptr_d;
      full_q  <= full_d;
      ridx_q  <= ridx_d;
      phase_q <= phase_d;
    end
    mem_q <= mem_d;
  end
endmodule : history_ring

/* File: design/pair_buffer.sv */
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
module pair_buffer #(
  parameter int W = 11
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] slot_q [2];
  logic [W-1:0] slot_d [2];
  logic [1:0]   cnt_q, cnt_d;
  logic         head_q, head_d;
  logic         push, pop;

  // Handshakes are honest: full refuses, empty offers nothing.
  assign in_ready  = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data  = slot_q[head_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next occupancy, head and slot contents.
  always_comb
  begin
    slot_d = slot_q;
    head_d = head_q;
    cnt_d  = cnt_q;
    if (push)
      slot_d[head_q ^ cnt_q[0]] = in_data;
    if (pop)
      head_d = ~head_q;
    if (push && !pop)
      cnt_d = cnt_q + 2'd1;
    else if (pop && !push)
      cnt_d = cnt_q - 2'd1;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cnt_q  <= 2'd0;
      head_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      head_q <= head_d;
    end
    slot_q <= slot_d;
  end
endmodule : pair_buffer

/* File: tb/host_model.sv */
/*
  Stand-in for the system controller behind the serial engine: byte writes
  and byte reads on the register strobe port of the fault history block.
  Assumes it is driven one nanosecond after a rising clock edge.
*/
module host_model
(
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle values; released lines show the inverse so stale data never matches.
  initial
  begin
    reg_addr  = 8'hff;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // One write strobe, then one idle cycle so strobes never merge.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clock);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
    @(posedge clock);
    #1;
  endtask : write_reg

  // One read strobe; the byte is registered at the edge that takes it.
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clock);
    #1;
    d        = reg_rdata;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    @(posedge clock);
    #1;
  endtask : read_reg
endmodule : host_model

/* File: tb/test_fault_history_buffer.sv */
/*
  Self-checking bench for the fault history block: registers, deglitch,
  histories, stop delay and latch-off, with a model queue per history.
  Assumes the host model drives the register port.
*/
module test_fault_history_buffer
  import history_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic                clock;
  logic                rst;
  logic [7:0]          reg_addr;
  logic                reg_wr;
  logic [7:0]          reg_wdata;
  logic                reg_rd;
  logic [7:0]          reg_rdata;
  logic                adc_valid;
  logic                adc_ready;
  logic                adc_is_current;
  logic [SAMPLE_W-1:0] adc_data;
  logic                cmp_sample;
  logic [NUM_CMP-1:0]  cmp_exceed;
  logic [NUM_CMP-1:0]  cmp_act;
  logic                protection_mode_input;
  logic                overcurrent_trip;
  logic                on_input;
  logic                soft_enable_a;
  logic                soft_enable_b;
  logic                channel_on;
  int                  miscompares;
  int                  cmp_count;
  logic [9:0]          exp_v[$];
  logic [9:0]          exp_i[$];
  logic [7:0]          rb;
  logic [7:0]          rst_addr[7] = '{8'h19, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h50};
  logic [7:0]          rst_val[7]  = '{8'h0f, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h19, 8'h00};

  fault_history_buffer dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_valid(adc_valid),
    .adc_ready(adc_ready), .adc_is_current(adc_is_current), .adc_data(adc_data),
    .cmp_sample(cmp_sample), .cmp_exceed(cmp_exceed), .cmp_act(cmp_act),
    .protection_mode_input(protection_mode_input), .overcurrent_trip(overcurrent_trip),
    .on_input(on_input), .soft_enable_a(soft_enable_a), .soft_enable_b(soft_enable_b),
    .channel_on(channel_on));

  host_model host (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

  // ----------------------------------------------------------------
  // Clock, verdict and watchdog
  // ----------------------------------------------------------------
  // The 100 ns period matches the 10 MHz system clock.
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic give_verdict();
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // The tests need about seven hundred cycles; about thirty times that means a hang.
  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Helper tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  // Offers one sample and waits for acceptance; valid stays up for the next call.
  task automatic push(input logic cur, input logic [9:0] val, input bit store);
    int n;
    n = 0;
    adc_valid      = 1'b1;
    adc_is_current = cur;
    adc_data       = val;
    while (adc_ready !== 1'b1 && n < 20)
    begin
      tick(1);
      n++;
    end
    tick(1);
    if (store && cur)
      exp_i.push_back(val);
    if (store && !cur)
      exp_v.push_back(val);
    if (exp_v.size() > HIST_DEPTH)
      void'(exp_v.pop_front());
  endtask : push

  // Lets the two-entry buffer drain into the ring.
  task automatic settle();
    adc_valid = 1'b0;
    tick(3);
  endtask : settle

  // Block read of a whole history, oldest sample first.
  task automatic check_ring(input logic cur, input bit full);
    logic [9:0] s;
    logic [7:0] b;
    for (int k = 0; k < (cur ? exp_i.size() : exp_v.size()); k++)
    begin
      s = cur ? exp_i[k] : exp_v[k];
      host.read_reg(cur ? ADDR_IPORT : ADDR_VPORT, b);
      check("history high byte", {2'b00, b}, {2'b00, s[9:2]});
      if (full)
      begin
        host.read_reg(cur ? ADDR_IPORT : ADDR_VPORT, b);
        check("history low bits", {2'b00, b}, {8'h00, s[1:0]});
      end
    end
  endtask : check_ring

  // One comparison result in, the action pulse checked the cycle after.
  task automatic step(input logic [4:0] e, input logic [4:0] exp);
    cmp_sample = 1'b1;
    cmp_exceed = e;
    tick(1);
    cmp_sample = 1'b0;
    check("cmp_act", {5'b00000, cmp_act}, {5'b00000, exp});
    tick(1);
  endtask : step

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    miscompares = 0;
    cmp_count = 0;
    rst = 1'b1;
    adc_valid = 1'b0;
    adc_is_current = 1'b0;
    adc_data = 10'h000;
    cmp_sample = 1'b0;
    cmp_exceed = 5'h00;
    protection_mode_input = 1'b0;
    overcurrent_trip = 1'b0;
    on_input = 1'b1;
    soft_enable_a = 1'b1;
    soft_enable_b = 1'b1;
    tick(3);
    rst = 1'b0;
    tick(2);
    check("channel_on", {9'h000, channel_on}, 10'h001);
    check("adc_ready", {9'h000, adc_ready}, 10'h001);
    for (int k = 0; k < 7; k++)
    begin
      host.read_reg(rst_addr[k], rb);
      check("reset value", {2'b00, rb}, {2'b00, rst_val[k]});
    end
    // Deglitch off, then on for all five, then a mixed pattern.
    step(5'h1f, 5'h1f);
    host.write_reg(ADDR_DGL_I, 8'h01);
    host.write_reg(ADDR_UNDERVOLT_DEGLITCH, 8'h03);
    host.write_reg(ADDR_OVERVOLT_DEGLITCH, 8'h03);
    host.read_reg(ADDR_UNDERVOLT_DEGLITCH, rb);
    check("undervolt_deglitch", {2'b00, rb}, 10'h003);
    step(5'h00, 5'h00);
    step(5'h1f, 5'h00);
    step(5'h1f, 5'h1f);
    step(5'h15, 5'h15);
    step(5'h0a, 5'h00);
    host.write_reg(ADDR_DGL_I, 8'h00);
    host.write_reg(ADDR_UNDERVOLT_DEGLITCH, 8'h02);
    host.write_reg(ADDR_OVERVOLT_DEGLITCH, 8'h01);
    step(5'h00, 5'h00);
    step(5'h1f, 5'h13);
    host.write_reg(ADDR_UNDERVOLT_DEGLITCH, 8'h00);
    host.write_reg(ADDR_OVERVOLT_DEGLITCH, 8'h00);
    // Current history: a sample offered while stopped must not appear.
    host.write_reg(ADDR_RUN, 8'h0b);
    push(1'b1, 10'h3ff, 1'b0);
    settle();
    host.write_reg(ADDR_RUN, 8'h0f);
    for (int k = 0; k < 3; k++)
      push(1'b1, 10'(k * 101 + 7), 1'b1);
    settle();
    check_ring(1'b1, 1'b0);
    // Voltage history wraps; a read freezes it against later samples.
    for (int k = 0; k < 53; k++)
      push(1'b0, 10'(k * 37 + 5), 1'b1);
    settle();
    check_ring(1'b0, 1'b0);
    push(1'b0, 10'h2aa, 1'b0);
    settle();
    host.write_reg(ADDR_RES, 8'h0e);
    host.write_reg(ADDR_RUN, 8'h0f);
    check_ring(1'b0, 1'b1);
    // Fault latch-off with a stop delay of two samples.
    host.write_reg(ADDR_DLY, 8'h02);
    host.write_reg(ADDR_RUN, 8'h0f);
    overcurrent_trip = 1'b1;
    tick(1);
    overcurrent_trip = 1'b0;
    tick(2);
    check("channel_on", {9'h000, channel_on}, 10'h000);
    for (int k = 0; k < 4; k++)
      push(1'b0, 10'(k * 5 + 1), k < 2);
    settle();
    soft_enable_b = 1'b0;
    tick(2);
    push(1'b0, 10'h155, 1'b0);
    settle();
    soft_enable_b = 1'b1;
    tick(3);
    check("channel_on", {9'h000, channel_on}, 10'h001);
    check_ring(1'b0, 1'b1);
    // Critical undervoltage under protection mode also latches off.
    protection_mode_input = 1'b1;
    step(5'h04, 5'h04);
    tick(2);
    check("channel_on", {9'h000, channel_on}, 10'h000);
    on_input = 1'b0;
    tick(2);
    on_input = 1'b1;
    tick(3);
    check("channel_on", {9'h000, channel_on}, 10'h001);
    // Current history in full resolution: two bytes for every sample.
    host.write_reg(ADDR_RES, 8'h0a);
    check_ring(1'b1, 1'b1);
    give_verdict();
  end
endmodule : test_fault_history_buffer
